// ### rtl/pbsram_pkg.sv
package pbsram_pkg;
  localparam int PBS_DEPTH = 131072;
  localparam int PBS_AW = 17;
  localparam int PBS_LANES = 4;
  localparam int PBS_LANE_W = 9;
  localparam int PBS_DW = 36;
  localparam logic [1:0] PBS_CNT_RST = 2'h0;
  localparam logic [35:0] PBS_DATA_RST = 36'h0;
  localparam logic [3:0] PBS_NO_WRITE = 4'h0;
  localparam logic [3:0] PBS_ALL_WRITE = 4'hf;
  typedef enum logic [1:0] {pbs_idle, pbs_read, pbs_write} pbs_cyc_t;
endpackage

// ### rtl/pbsram_burst_cnt.sv
`timescale 1ns/1ps
`default_nettype none
module pbsram_burst_cnt
  import pbsram_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic load,
  input wire logic step,
  input wire logic order_select,
  input wire logic [1:0] start_low,
  output logic [1:0] low_addr
);
  typedef struct packed {
    logic [1:0] base;
    logic [1:0] cnt;
  } pbs_cnt_st_t;
  pbs_cnt_st_t st_r;
  pbs_cnt_st_t st_nxt;
  ////////////////////////////////////////////////////////////////
  // load start bits on a strobe, step count on advance
  always_comb begin
    st_nxt = st_r;
    if (load) begin
      st_nxt.base = start_low;
      st_nxt.cnt = 2'h0;
    end else if (step) begin
      st_nxt.cnt = st_r.cnt + 2'h1; // [RQ4] [RQ5]
    end
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
  // linear adds, interleaved xors; strap read unregistered
  assign low_addr = order_select ? (st_r.base ^ st_r.cnt)
                                 : 2'(st_r.base + st_r.cnt); // [RQ6] [RQ21]
endmodule
`default_nettype wire

// ### rtl/pbsram_array.sv
`timescale 1ns/1ps
`default_nettype none
module pbsram_array
  import pbsram_pkg::*;
#(
  parameter int AW = PBS_AW,
  parameter int LANES = PBS_LANES,
  parameter int LW = PBS_LANE_W
) (
  input wire logic clk,
  input wire logic [AW-1:0] addr,
  input wire logic [LANES-1:0] lane_we,
  input wire logic [LANES*LW-1:0] wdata,
  output logic [LANES*LW-1:0] rdata
);
  logic [LANES*LW-1:0] mem [0:(1<<AW)-1];
  ////////////////////////////////////////////////////////////////
  // per-lane write, each strobe touches only its lane
  genvar g;
  generate
    for (g = 0; g < LANES; g++) begin : g_lane
      always_ff @(posedge clk) begin
        if (lane_we[g]) begin
          mem[addr][g*LW +: LW] <= wdata[g*LW +: LW]; // [RQ10]
        end
      end
    end
  endgenerate
  // asynchronous array read, registered by the caller
  assign rdata = mem[addr];
endmodule
`default_nettype wire

// ### rtl/pbsram_top.sv
// Overview of operation
// RQ1: stores 128K words of 36 bits, addressed by registers and counter.
// RQ2: address, data and controls registered on the rising edge.
// RQ3: either address strobe starts a burst from the external address.
// RQ4: a 2-bit counter makes the following burst addresses.
// RQ5: burst-step advances the counter one step.
// RQ6: order select low is linear, high interleaved, not registered.
// RQ7: order select is held static by the outside party.
// RQ8: the outside party wires its two address LSBs to bits 1:0.
// RQ9: writes start at the clock edge and are self-timed.
// RQ10: four byte lanes, each with its own write strobe.
// RQ11: byte lanes write only together with the normal write enable.
// RQ12: global write, or all lanes with normal write, writes all lanes.
// RQ13: read data passes through one output register stage.
// RQ14: output enable low drives the data pins, high floats them.
// RQ15: controller strobe aborts a burst and starts read, write or deselect.
// RQ16: processor strobe aborts a burst, never deselects while primary high.
// RQ17: primary enable high blocks processor strobe, controller strobe deselects.
// RQ18: depth enable high must be high to select.
// RQ19: depth enable low must be low to select.
// RQ20: byte-only users tie global write high.
// RQ21: linear adds one modulo four, interleaved xors a step count.
// RQ22: with no strobe and no step, address and cycle type repeat; the code makes the cycle a write while write controls stand.
`timescale 1ns/1ps
`default_nettype none
module pbsram_top
  import pbsram_pkg::*;
#(
  parameter int AW = PBS_AW,
  parameter int LANES = PBS_LANES,
  parameter int LW = PBS_LANE_W
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [AW-1:0] address_in,
  input wire logic [LANES*LW-1:0] data_lane_in,
  output logic [LANES*LW-1:0] data_lane_out,
  output logic [LANES*LW-1:0] data_lane_oe,
  input wire logic ctrl_addr_strobe_n,
  input wire logic cpu_addr_strobe_n,
  input wire logic burst_step_n,
  input wire logic [LANES-1:0] lane_write_n,
  input wire logic all_byte_write_n,
  input wire logic normal_write_n,
  input wire logic primary_enable_n,
  input wire logic depth_enable_hi,
  input wire logic depth_enable_lo_n,
  input wire logic output_enable_n,
  input wire logic order_select
);
  ////////////////////////////////////////////////////////////////
  // state of the block
  typedef struct packed {
    logic [AW-1:0] addr;
    logic [LANES*LW-1:0] din;
    logic ctrl_addr_strobe_n_n;
    logic cpu_addr_strobe_n_n;
    logic adv_n;
    logic [LANES-1:0] bw_n;
    logic gw_n;
    logic w_n;
    logic ce1_n;
    logic ce2;
    logic ce3_n;
    logic selected;
    pbs_cyc_t cyc;
    logic rd_pend;
    logic [LANES*LW-1:0] dout;
    logic oe_n;
    // second stage: write data and lane strobes wait for the address register
    logic [LANES*LW-1:0] din_d;
    logic [LANES-1:0] we_d;
    // three-flop synchroniser for the asynchronous output enable pin
    logic oe_s1;
    logic oe_s2;
    logic oe_s3;
  } pbs_st_t;
  pbs_st_t st_r;
  pbs_st_t st_nxt;
  logic start_c;
  logic start_p;
  logic start_any;
  logic step;
  logic sel_now;
  logic wr_any;
  logic [LANES-1:0] lane_we;
  logic [1:0] low_addr;
  logic [AW-1:0] arr_addr;
  logic [LANES*LW-1:0] rdata;
  pbs_cyc_t new_cyc;
  ////////////////////////////////////////////////////////////////
  // lane write decode, shared by array strobes and cycle type
  function automatic logic [LANES-1:0] lane_dec(input logic gw_n, input logic w_n,
                                                input logic [LANES-1:0] bw_n);
    logic [LANES-1:0] r;
    r = PBS_NO_WRITE;
    if (!gw_n) begin
      r = PBS_ALL_WRITE; // [RQ12]
    end else if (!w_n) begin
      r = ~bw_n; // [RQ11] [RQ12]
    end
    return r;
  endfunction
  ////////////////////////////////////////////////////////////////
  // cycle start decode from registered inputs
  always_comb begin
    sel_now = !st_r.ce1_n && st_r.ce2 && !st_r.ce3_n; // [RQ18] [RQ19]
    // processor strobe ignored while primary enable is high
    start_p = !st_r.cpu_addr_strobe_n_n && !st_r.ce1_n; // [RQ16] [RQ17]
    start_c = !st_r.ctrl_addr_strobe_n_n; // [RQ15]
    start_any = start_p || start_c; // [RQ3]
    step = !start_any && !st_r.adv_n && st_r.selected; // [RQ5]
    // processor strobe cycles are reads; write controls are taken later
    wr_any = start_c && (lane_dec(st_r.gw_n, st_r.w_n, st_r.bw_n) != PBS_NO_WRITE);
    if (start_any && !sel_now) begin
      new_cyc = pbs_idle; // [RQ15] [RQ17]
    end else if (start_any) begin
      new_cyc = wr_any ? pbs_write : pbs_read;
    end else if (st_r.selected &&
                 lane_dec(st_r.gw_n, st_r.w_n, st_r.bw_n) != PBS_NO_WRITE) begin
      new_cyc = pbs_write;
    end else if (st_r.selected) begin
      new_cyc = st_r.adv_n ? st_r.cyc : pbs_read; // [RQ22]
    end else begin
      new_cyc = pbs_idle;
    end
  end
  ////////////////////////////////////////////////////////////////
  // burst counter and address
  pbsram_burst_cnt u_cnt (
    .clk(clk),
    .nrst(nrst),
    .load(start_any),
    .step(step),
    .order_select(order_select),
    .start_low(st_r.addr[1:0]),
    .low_addr(low_addr)
  );
  logic [AW-1:0] base_r;
  logic [AW-1:0] base_nxt;
  always_comb begin
    base_nxt = start_any ? st_r.addr : base_r; // [RQ3] [RQ22]
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      base_r <= '0;
    end else begin
      base_r <= base_nxt;
    end
  end
  // upper bits from the latched address, low two from the counter
  assign arr_addr = {base_r[AW-1:2], low_addr}; // [RQ1] [RQ4]
  // array write for the beat whose address now stands, self-timed in one clock
  // data and strobes were delayed one stage so they meet the registered address
  // a new strobe in this cycle does not cancel the write of the beat before it
  assign lane_we = (st_r.cyc == pbs_write) ? st_r.we_d : PBS_NO_WRITE; // [RQ9]
  pbsram_array #(.AW(AW), .LANES(LANES), .LW(LW)) u_array (
    .clk(clk),
    .addr(arr_addr),
    .lane_we(lane_we),
    .wdata(st_r.din_d),
    .rdata(rdata)
  );
  ////////////////////////////////////////////////////////////////
  // next state: register inputs and pipeline read data
  always_comb begin
    st_nxt = st_r;
    st_nxt.addr = address_in; // [RQ2]
    st_nxt.din = data_lane_in;
    st_nxt.ctrl_addr_strobe_n_n = ctrl_addr_strobe_n;
    st_nxt.cpu_addr_strobe_n_n = cpu_addr_strobe_n;
    st_nxt.adv_n = burst_step_n;
    st_nxt.bw_n = lane_write_n;
    st_nxt.gw_n = all_byte_write_n;
    st_nxt.w_n = normal_write_n;
    st_nxt.ce1_n = primary_enable_n;
    st_nxt.ce2 = depth_enable_hi;
    st_nxt.ce3_n = depth_enable_lo_n;
    if (start_any) begin
      st_nxt.selected = sel_now;
    end
    st_nxt.cyc = new_cyc;
    st_nxt.rd_pend = (st_r.cyc == pbs_read);
    if (st_r.cyc == pbs_read) begin
      st_nxt.dout = rdata; // [RQ13]
    end
    // align write data and lane strobes with the address of their own beat
    st_nxt.din_d = st_r.din;
    st_nxt.we_d = lane_dec(st_r.gw_n, st_r.w_n, st_r.bw_n); // [RQ10] [RQ11]
    // output enable pin is asynchronous: three flops, change taken on agreement
    st_nxt.oe_s1 = output_enable_n;
    st_nxt.oe_s2 = st_r.oe_s1;
    st_nxt.oe_s3 = st_r.oe_s2;
    if (st_r.oe_s2 == st_r.oe_s3) begin
      st_nxt.oe_n = st_r.oe_s3; // [RQ14]
    end
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_r <= '0;
      st_r.ctrl_addr_strobe_n_n <= 1'b1;
      st_r.cpu_addr_strobe_n_n <= 1'b1;
      st_r.adv_n <= 1'b1;
      st_r.bw_n <= '1;
      st_r.gw_n <= 1'b1;
      st_r.w_n <= 1'b1;
      st_r.ce1_n <= 1'b1;
      st_r.oe_n <= 1'b1;
      st_r.oe_s1 <= 1'b1;
      st_r.oe_s2 <= 1'b1;
      st_r.oe_s3 <= 1'b1;
      st_r.cyc <= pbs_idle;
    end else begin
      st_r <= st_nxt;
    end
  end
  ////////////////////////////////////////////////////////////////
  // outputs straight from flip-flops; enable follows output enable
  assign data_lane_out = st_r.dout;
  assign data_lane_oe = {(LANES*LW){!st_r.oe_n}}; // [RQ14]
  ////////////////////////////////////////////////////////////////
  // checks
  sequence s_ctrl_start;
    !ctrl_addr_strobe_n && !primary_enable_n && depth_enable_hi && !depth_enable_lo_n
      && !cpu_addr_strobe_n == 1'b0 && all_byte_write_n && normal_write_n;
  endsequence
  chk_read_pipe: assert property (@(posedge clk) disable iff (!nrst) // [RQ13]
    st_r.cyc == pbs_read |=> data_lane_out == $past(rdata))
    else $error("read data not registered");
  // a steady pin level reaches the drivers three edges after it is sampled
  chk_oe_follow: assert property (@(posedge clk) disable iff (!nrst) // [RQ14]
    $past(output_enable_n, 3) == $past(output_enable_n, 4)
      |-> data_lane_oe[0] == !$past(output_enable_n, 4))
    else $error("output enable wrong");
  chk_desel: assert property (@(posedge clk) disable iff (!nrst) // [RQ17]
    !ctrl_addr_strobe_n && primary_enable_n |=> ##1 st_r.cyc == pbs_idle)
    else $error("controller strobe did not deselect");
  chk_cpu_block: assert property (@(posedge clk) disable iff (!nrst) // [RQ16]
    !cpu_addr_strobe_n && primary_enable_n |=> !start_p)
    else $error("processor strobe taken while disabled");
  chk_ctrl_read: assert property (@(posedge clk) disable iff (!nrst) // [RQ15]
    s_ctrl_start |=> ##1 st_r.cyc == pbs_read)
    else $error("controller read not started");
  // write controls act one cycle after they stand in the input register
  chk_gw_all: assert property (@(posedge clk) disable iff (!nrst) // [RQ12]
    lane_we != PBS_NO_WRITE && !$past(st_r.gw_n) |-> lane_we == PBS_ALL_WRITE)
    else $error("global write not all lanes");
  chk_byte_gate: assert property (@(posedge clk) disable iff (!nrst) // [RQ11]
    $past(st_r.gw_n) && $past(st_r.w_n) |-> lane_we == PBS_NO_WRITE)
    else $error("lane written without write enable");
  chk_lane_only: assert property (@(posedge clk) disable iff (!nrst) // [RQ10]
    st_r.cyc == pbs_write && $past(st_r.gw_n) && !$past(st_r.w_n)
      |-> lane_we == ~$past(st_r.bw_n))
    else $error("lane strobe not its own lane");
  chk_load_addr: assert property (@(posedge clk) disable iff (!nrst) // [RQ3]
    start_any |=> arr_addr == $past(st_r.addr))
    else $error("burst start address wrong");
  chk_hold: assert property (@(posedge clk) disable iff (!nrst) // [RQ22]
    !start_any && !step |=> arr_addr == $past(arr_addr))
    else $error("burst address moved");
  chk_linear: assert property (@(posedge clk) disable iff (!nrst) // [RQ21]
    step && !order_select && $stable(order_select)
      |=> low_addr == 2'($past(low_addr) + 2'h1))
    else $error("linear step wrong");
  // interleaved: low bits xor start bits is the step count, which rises by one
  sequence s_inter_step;
    step && order_select && $stable(order_select);
  endsequence
  chk_interleave: assert property (@(posedge clk) disable iff (!nrst) // [RQ21]
    s_inter_step |=> (low_addr ^ base_r[1:0])
      == 2'(($past(low_addr) ^ $past(base_r[1:0])) + 2'h1))
    else $error("interleaved step wrong");
  // controller strobe with global write, chip enabled, writes all lanes
  sequence s_ctrl_gwrite;
    !ctrl_addr_strobe_n && !all_byte_write_n && !primary_enable_n
      && depth_enable_hi && !depth_enable_lo_n;
  endsequence
  chk_ctrl_write: assert property (@(posedge clk) disable iff (!nrst) // [RQ9]
    s_ctrl_gwrite |=> ##1 lane_we == PBS_ALL_WRITE)
    else $error("controller write not started");
  // depth enables out of range deselect on a controller strobe
  chk_depth_hi: assert property (@(posedge clk) disable iff (!nrst) // [RQ18]
    !ctrl_addr_strobe_n && !depth_enable_hi |=> ##1 st_r.cyc == pbs_idle)
    else $error("depth enable high not honoured");
  chk_depth_lo: assert property (@(posedge clk) disable iff (!nrst) // [RQ19]
    !ctrl_addr_strobe_n && depth_enable_lo_n |=> ##1 st_r.cyc == pbs_idle)
    else $error("depth enable low not honoured");
endmodule
`default_nettype wire

// ### dv/pbsram_cpu_model.sv
`timescale 1ns/1ps
`default_nettype none
module pbsram_cpu_model
  import pbsram_pkg::*;
(
  input wire logic clk,
  output logic [PBS_AW-1:0] addr,
  output logic [PBS_DW-1:0] din,
  output logic [1:0] strobe_n,
  output logic step_n,
  output logic [5:0] wctl_n,
  output logic [2:0] en
);
  // bus parked idle, global write parked high
  initial begin
    strobe_n = 2'h3;
    step_n = 1'b1;
    wctl_n = 6'h3f;
    addr = '0;
    din = '0;
    en = 3'h2;
  end
  // one cycle: change after the falling edge, hold through the rising edge
  task automatic beat(input logic [1:0] s, input logic st, input logic [PBS_AW-1:0] a,
                      input logic [PBS_DW-1:0] d, input logic [5:0] w, input logic [2:0] e);
    @(negedge clk);
    strobe_n = s;
    step_n = st;
    addr = a;
    wctl_n = w;
    en = e;
    din = (&w[5:4]) ? ~din : d; // undriven data never holds its last value
    @(posedge clk);
  endtask
endmodule
`default_nettype wire

// ### dv/pipelined_burst_sync_sram_bench.sv
`timescale 1ns/1ps
`default_nettype none
`define CMP(g, e) begin check_count++; if ((g) !== (e)) begin mismatches++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, g, e); end end
module pipelined_burst_sync_sram_bench;
  import pbsram_pkg::*;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic oe_n = 1'b1;
  logic order = 1'b0;
  logic [PBS_AW-1:0] addr;
  logic [PBS_DW-1:0] din;
  logic [PBS_DW-1:0] dout;
  logic [PBS_DW-1:0] oe;
  logic [1:0] strobe_n;
  logic step_n;
  logic [5:0] wctl_n;
  logic [2:0] en;
  logic [PBS_DW-1:0] mem [int];
  logic [PBS_DW-1:0] exp_q [$];
  logic [5:0] wt [4] = '{6'h30, 6'h20, 6'h20, 6'h10};
  logic [2:0] dsel [3] = '{3'h0, 3'h6, 3'h3};
  logic [PBS_AW-1:0] base;
  int mismatches = 0;
  int check_count = 0;
  always #20 clk = ~clk;
  pbsram_cpu_model pm (.clk(clk), .addr(addr), .din(din), .strobe_n(strobe_n),
    .step_n(step_n), .wctl_n(wctl_n), .en(en));
  pbsram_top dut (.clk(clk), .nrst(nrst), .address_in(addr), .data_lane_in(din),
    .data_lane_out(dout), .data_lane_oe(oe), .ctrl_addr_strobe_n(strobe_n[1]),
    .cpu_addr_strobe_n(strobe_n[0]), .burst_step_n(step_n), .lane_write_n(wctl_n[3:0]),
    .all_byte_write_n(wctl_n[5]), .normal_write_n(wctl_n[4]), .primary_enable_n(en[0]),
    .depth_enable_hi(en[1]), .depth_enable_lo_n(en[2]), .output_enable_n(oe_n),
    .order_select(order));
  // verdict and end of run
  task automatic tally_and_finish;
    $display("checks=%0d mismatches=%0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // n active beats plus two idle ones; reads compared two edges after issue
  task automatic burst(input logic [1:0] s, input logic wr, input int n, input logic [5:0] w,
                       input logic [2:0] e);
    logic [PBS_DW-1:0] d;
    logic [PBS_AW-1:0] a;
    logic [3:0] ln;
    for (int i = 0; i < n + 2; i++) begin
      d = PBS_DW'({$urandom, $urandom});
      a = base;
      a[1:0] = order ? base[1:0] ^ 2'(i) : base[1:0] + 2'(i);
      ln = !w[5] ? 4'hf : (!w[4] ? ~w[3:0] : 4'h0);
      if (i >= n) begin
        pm.beat(2'h3, 1'b1, base, d, 6'h3f, e);
      end else begin
        pm.beat(i == 0 ? s : 2'h3, i == 0, base, d, wr ? w : 6'h3f, e);
      end
      if (i < n && wr && e == 3'h2) begin
        for (int k = 0; k < 4; k++) begin
          if (ln[k]) mem[a][k*9 +: 9] = d[k*9 +: 9];
        end
      end
      if (i < n && !wr) exp_q.push_back(mem[a]);
      #1;
      if (i >= 2 && exp_q.size() > 0) `CMP(dout, exp_q.pop_front())
    end
  endtask
  // two passes, linear then interleaved, order changed only inside reset
  initial begin
    void'($urandom(46));
    for (int p = 0; p < 2; p++) begin
      nrst = 1'b0;
      order = p[0];
      repeat (20) @(posedge clk);
      @(negedge clk);
      nrst = 1'b1;
      oe_n = 1'b0;
      base = PBS_AW'($urandom);
      burst(2'h1, 1'b1, 4, 6'h1f, 3'h2);
      burst(2'h2, 1'b0, 4, 6'h3f, 3'h2);
      for (int j = 0; j < 4; j++) begin
        burst(2'h1, 1'b1, 4, wt[j] | (j == 2 ? 6'h0 : 6'($urandom % 16)), 3'h2);
        burst(2'h1, 1'b0, 4, 6'h3f, 3'h2);
      end
      for (int j = 0; j < 3; j++) begin
        burst(j == 2 ? 2'h0 : 2'h1, 1'b1, 1, 6'h1f, dsel[j]);
        burst(2'h1, 1'b0, 4, 6'h3f, 3'h2);
      end
      `CMP(oe, {PBS_DW{1'b1}})
      @(negedge clk);
      oe_n = 1'b1;
      repeat (4) @(posedge clk);
      #1;
      `CMP(oe, {PBS_DW{1'b0}})
    end
    tally_and_finish;
  end
  // hang guard
  initial begin
    repeat (5000) @(posedge clk);
    mismatches++;
    tally_and_finish;
  end
endmodule
`default_nettype wire
